//--- hdl/pwr_clk_pkg.sv
// shared constants and types for the power and clock mode control block
package pwr_clk_pkg;

  localparam int         ADDR_W          = 7;
  localparam int         DATA_W          = 8;
  localparam int         NUM_GP          = 4;
  localparam int         WAKE_LEN        = 64;

  // register indices
  localparam logic [6:0] REG_PWR_CLK     = 7'h15;
  localparam logic [6:0] REG_CONV_MODE   = 7'h16;
  localparam logic [6:0] REG_IF_FMT      = 7'h17;
  localparam logic [6:0] REG_FILTER      = 7'h18;
  localparam logic [6:0] REG_TARGET      = 7'h19;
  localparam logic [6:0] REG_DUTY        = 7'h1a;
  localparam logic [6:0] REG_GP_DIR      = 7'h1b;
  localparam logic [6:0] REG_GP_OUT      = 7'h1c;
  localparam logic [6:0] REG_GP_IN       = 7'h1d;
  localparam logic [6:0] REG_STATUS      = 7'h1e;

  // power and clock register fields
  localparam int         CLKSRC_LSB      = 6;
  localparam int         PMODE_LSB       = 0;
  localparam int         DIV_LSB         = 3;
  localparam logic [1:0] CLKSRC_LVDS     = 2'h3;

  // interface format fields
  localparam int         FMT_LEN16_BIT   = 0;
  localparam int         FMT_STAT_BIT    = 1;
  localparam int         FMT_CRC_BIT     = 2;
  localparam int         FMT_STREAM_BIT  = 3;

  localparam logic [7:0] RST_PWR_CLK     = 8'h00;
  localparam logic [7:0] RST_CONV_MODE   = 8'h00;
  localparam logic [7:0] RST_IF_FMT      = 8'h00;
  localparam logic [7:0] RST_FILTER      = 8'h00;
  localparam logic [7:0] RST_TARGET      = 8'h00;
  localparam logic [7:0] RST_DUTY        = 8'h0f;
  localparam logic [7:0] RST_ZERO        = 8'h00;

  localparam logic [7:0] CRC_POLY        = 8'h07;
  localparam logic [7:0] CRC_SEED        = 8'hff;

  typedef enum logic [2:0] {
    PM_FAST, PM_MEDIUM, PM_LOW, PM_STANDBY, PM_POWERDOWN
  } pwr_mode_t;

  typedef enum logic [1:0] {
    CM_CONTINUOUS, CM_SINGLE, CM_ONESHOT, CM_DUTY
  } conv_mode_t;

  typedef enum logic [1:0] {
    CS_CMOS, CS_CRYSTAL, CS_LVDS
  } clk_src_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] data;
    logic [7:0]  status;
  } conv_res_t;

  typedef struct packed {
    logic        valid;
    logic [5:0]  nbits;
    logic [39:0] word;
  } out_word_t;

endpackage : pwr_clk_pkg

//--- hdl/wake_detect.sv
// serial wake code detector: one then zeros while select is low
module wake_detect #(
  parameter int LEN = 64
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  // synchronised serial pins
  input  wire logic sclk_rise_i,
  input  wire logic cs_n_i,
  input  wire logic sdi_i,
  // result
  output logic      wake_o
);
  initial if (LEN < 2 || LEN > 127) $error("wake_detect: LEN out of range");

  logic [6:0] cnt_r;
  logic       armed_r;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r   <= 7'h00;
      armed_r <= 1'b0;
    end else if (cs_n_i) begin
      cnt_r   <= 7'h00;
      armed_r <= 1'b0;
    end else if (sclk_rise_i) begin
      if (!armed_r) begin
        armed_r <= sdi_i;
        cnt_r   <= 7'h01;
      end else if (sdi_i) begin
        cnt_r   <= 7'h01;
      end else if (cnt_r < 7'(LEN)) begin
        cnt_r   <= cnt_r + 7'h01;
      end
    end
  end

  assign wake_o = armed_r && (cnt_r == 7'(LEN));

endmodule : wake_detect

//--- hdl/power_clock_mode_control.sv
// power, clock source, conversion mode and output format control
// Function
// - modulator clock enable from master clock divided by two up to sixteen
// - strap low selects single-ended cmos master clock
// - strap high without differential field selects crystal
// - differential clock needs strap high plus field bits 7:6 in serial mode
// - power-down stops all blocks and discards every configuration register
// - only the wake code leaves power-down, register accesses do not
// - wake code is a one then 63 zeros clocked with select low
// - standby stops analog clock and power, keeps registers
// - power modes fast, medium, low power, standby, power-down
// - continuous read results are 24 or 16 bits long
// - status bits optionally appended to each result
// - optional check code appended to transmitted data
// - streaming mode shifts results out without per-result commands
// - single conversion does one conversion then returns to standby
// - one-shot converts only on a host trigger pulse
// - continuous mode converts back to back without pause
// - duty-cycled mode waits in standby a set interval after each result
// - host selects conversion target: inputs, temperature, diagnostics
// - host selects filter: sinc5, low-ripple fir, sinc3
// - four general-purpose pins driven or read by the host
module power_clock_mode_control
  import pwr_clk_pkg::*;
#(
  parameter int NUM_PINS = 4
) (
  // clock and reset
  input  wire logic                          core_clk_i,
  input  wire logic                          reset_i,
  // straps and control mode
  input  wire logic                          clock_sel_i,
  input  wire logic                          serial_mode_i,
  // register port from the serial front end
  input  wire pwr_clk_pkg::reg_req_t         req_i,
  output logic [7:0]                         rdata_o,
  output logic                               rvalid_o,
  // raw serial pins for wake detection
  input  wire logic                          sclk_i,
  input  wire logic                          cs_n_i,
  input  wire logic                          sdi_i,
  // trigger and conversion engine
  input  wire logic                          start_i,
  input  wire pwr_clk_pkg::conv_res_t        result_i,
  output logic                               mod_clk_en_o,
  output logic                               conv_run_o,
  output logic                               analog_on_o,
  output logic                               digital_on_o,
  output logic [1:0]                         clk_src_o,
  output logic [1:0]                         filter_o,
  output logic [2:0]                         target_o,
  output logic                               data_ready_o,
  // output word to the serial shifter
  input  wire logic                          word_taken_i,
  output pwr_clk_pkg::out_word_t             word_o,
  output logic                               stream_o,
  // general-purpose pins
  input  wire logic [NUM_PINS-1:0]           gp_in_i,
  output logic [NUM_PINS-1:0]                gp_out_o,
  output logic [NUM_PINS-1:0]                gp_oe_o
);
  import pwr_clk_pkg::*;

  initial if (NUM_PINS < 1 || NUM_PINS > DATA_W) $error("bad NUM_PINS");

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] sclk_s_r, cs_s_r, sdi_s_r, start_s_r;
  logic       sclk_d_r, start_d_r;
  logic [NUM_PINS-1:0] gp_s1_r, gp_s2_r;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_s_r  <= 2'h0;
      cs_s_r    <= 2'h3;
      sdi_s_r   <= 2'h0;
      start_s_r <= 2'h0;
      sclk_d_r  <= 1'b0;
      start_d_r <= 1'b0;
      gp_s1_r   <= '0;
      gp_s2_r   <= '0;
    end else begin
      sclk_s_r  <= {sclk_s_r[0], sclk_i};
      cs_s_r    <= {cs_s_r[0], cs_n_i};
      sdi_s_r   <= {sdi_s_r[0], sdi_i};
      start_s_r <= {start_s_r[0], start_i};
      sclk_d_r  <= sclk_s_r[1];
      start_d_r <= start_s_r[1];
      gp_s1_r   <= gp_in_i;
      gp_s2_r   <= gp_s1_r;
    end
  end

  wire sclk_rise  = sclk_s_r[1] & ~sclk_d_r;
  wire start_rise = start_s_r[1] & ~start_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [7:0] pwr_clk_r, conv_mode_r, if_fmt_r, filter_r, target_r, duty_r;
  logic [7:0] gp_dir_r, gp_out_r;
  logic       pd_r;
  logic       wake;
  logic       busy_flag_r;

  // 1 = power-down write accepted this cycle
  wire pd_enter = req_i.wr && !pd_r && req_i.addr == REG_PWR_CLK
                  && req_i.wdata[PMODE_LSB +: 3] == 3'(PM_POWERDOWN);

  // contents are lost on entry and defaults return on wake, so any write
  // during power-down is ignored rather than kept for later
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pwr_clk_r   <= RST_PWR_CLK;
      conv_mode_r <= RST_CONV_MODE;
      if_fmt_r    <= RST_IF_FMT;
      filter_r    <= RST_FILTER;
      target_r    <= RST_TARGET;
      duty_r      <= RST_DUTY;
      gp_dir_r    <= RST_ZERO;
      gp_out_r    <= RST_ZERO;
    end else if (pd_enter || (pd_r && wake)) begin
      pwr_clk_r   <= RST_PWR_CLK;
      conv_mode_r <= RST_CONV_MODE;
      if_fmt_r    <= RST_IF_FMT;
      filter_r    <= RST_FILTER;
      target_r    <= RST_TARGET;
      duty_r      <= RST_DUTY;
      gp_dir_r    <= RST_ZERO;
      gp_out_r    <= RST_ZERO;
    end else if (req_i.wr && !pd_r) begin
      unique case (req_i.addr)
        REG_PWR_CLK:   pwr_clk_r   <= req_i.wdata;
        REG_CONV_MODE: conv_mode_r <= req_i.wdata;
        REG_IF_FMT:    if_fmt_r    <= req_i.wdata;
        REG_FILTER:    filter_r    <= req_i.wdata;
        REG_TARGET:    target_r    <= req_i.wdata;
        REG_DUTY:      duty_r      <= req_i.wdata;
        REG_GP_DIR:    gp_dir_r    <= req_i.wdata;
        REG_GP_OUT:    gp_out_r    <= req_i.wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down and wake
  wake_detect #(
    .LEN (WAKE_LEN)
  ) u_wake (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .sclk_rise_i (sclk_rise),
    .cs_n_i      (cs_s_r[1]),
    .sdi_i       (sdi_s_r[1]),
    .wake_o      (wake)
  );

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pd_r <= 1'b0;
    end else if (pd_enter) begin
      pd_r <= 1'b1;
    end else if (pd_r && wake) begin
      pd_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  typedef enum logic [1:0] {S_IDLE, S_CONV, S_WAIT} seq_t;
  seq_t       seq_r;
  logic       standby_tick;
  logic [2:0] pm_field;
  logic       standby;
  logic [3:0] div_ratio;

  assign pm_field = pwr_clk_r[PMODE_LSB +: 3];
  // the duty-cycle rest is a true standby, so the analog side sleeps too
  assign standby  = pd_r || pm_field == 3'(PM_STANDBY) || busy_flag_r || standby_tick;

  // a three-bit field picks 2..16 in steps of two
  assign div_ratio = {pwr_clk_r[DIV_LSB +: 3], 1'b0} + 4'h2 - 4'h1;

  always_comb begin
    if (!clock_sel_i) begin
      clk_src_o = 2'(CS_CMOS);
    end else if (serial_mode_i && pwr_clk_r[CLKSRC_LSB +: 2] == CLKSRC_LVDS) begin
      clk_src_o = 2'(CS_LVDS);
    end else begin
      clk_src_o = 2'(CS_CRYSTAL);
    end
  end

  assign analog_on_o  = !standby;
  assign digital_on_o = !pd_r;
  assign filter_o     = filter_r[1:0];
  assign target_o     = target_r[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // modulator clock divider
  logic [3:0] div_cnt_r;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_cnt_r    <= 4'h0;
      mod_clk_en_o <= 1'b0;
    end else if (standby || pd_enter) begin   // no stray pulse as power-down starts
      div_cnt_r    <= 4'h0;
      mod_clk_en_o <= 1'b0;
    end else if (div_cnt_r >= div_ratio) begin
      div_cnt_r    <= 4'h0;
      mod_clk_en_o <= 1'b1;
    end else begin
      div_cnt_r    <= div_cnt_r + 4'h1;
      mod_clk_en_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencing
  logic [7:0] wait_cnt_r;
  conv_mode_t cmode;

  assign cmode      = conv_mode_t'(conv_mode_r[1:0]);
  assign conv_run_o = (seq_r == S_CONV) && !standby;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_r       <= S_IDLE;
      wait_cnt_r  <= 8'h00;
      busy_flag_r <= 1'b0;
    end else if (pd_r || req_i.wr && req_i.addr == REG_CONV_MODE) begin
      seq_r       <= S_IDLE;
      wait_cnt_r  <= 8'h00;
      // a single result landing with the rewrite still sets the flag
      busy_flag_r <= !pd_r && seq_r == S_CONV && result_i.valid && cmode == CM_SINGLE;
    end else begin
      unique case (seq_r)
        S_IDLE: begin
          if (cmode == CM_ONESHOT) begin
            if (start_rise) seq_r <= S_CONV;
          end else if (cmode == CM_SINGLE) begin
            if (!busy_flag_r) seq_r <= S_CONV;
          end else begin
            seq_r <= S_CONV;
          end
        end
        S_CONV: begin
          if (result_i.valid) begin
            unique case (cmode)
              CM_SINGLE: begin
                busy_flag_r <= 1'b1;
                seq_r       <= S_IDLE;
              end
              CM_ONESHOT: seq_r <= S_IDLE;
              CM_DUTY: begin
                wait_cnt_r <= duty_r;
                seq_r      <= S_WAIT;
              end
              CM_CONTINUOUS: seq_r <= S_CONV;
            endcase
          end
        end
        S_WAIT: begin
          if (wait_cnt_r == 8'h00) begin
            seq_r <= S_CONV;
          end else if (mod_clk_en_o || standby_tick) begin
            wait_cnt_r <= wait_cnt_r - 8'h01;
          end
        end
        default: seq_r <= S_IDLE;
      endcase
    end
  end

  // standby interval counts in core cycles while the modulator sleeps
  assign standby_tick = seq_r == S_WAIT;

  ////////////////////////////////////////////////////////////////////////////
  // output word build: length, status and check code
  function automatic logic [7:0] crc8(input logic [39:0] w, input logic [5:0] n);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 39; i >= 0; i--) begin
      if (i >= 40 - int'(n)) begin
        c = (c[7] ^ w[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
    end
    return c;
  endfunction : crc8

  logic [39:0] base_w;
  logic [5:0]  base_n;
  logic [5:0]  tot_n;

  always_comb begin
    base_w = '0;
    base_n = 6'd24;
    if (if_fmt_r[FMT_LEN16_BIT]) begin
      base_w[39:24] = result_i.data[23:8];
      base_n        = 6'd16;
    end else begin
      base_w[39:16] = result_i.data;
    end
    if (if_fmt_r[FMT_STAT_BIT]) begin
      base_w = base_w | ({result_i.status, 32'h0} >> base_n);
      base_n = base_n + 6'd8;
    end
    tot_n = base_n;
    if (if_fmt_r[FMT_CRC_BIT]) begin
      base_w = base_w | ({crc8(base_w, base_n), 32'h0} >> base_n);
      tot_n  = base_n + 6'd8;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      word_o       <= '0;
      data_ready_o <= 1'b0;
    end else if (result_i.valid && !pd_r) begin
      word_o.valid <= 1'b1;
      word_o.nbits <= tot_n - 6'd1;
      word_o.word  <= base_w;
      data_ready_o <= 1'b1;
    end else if (word_taken_i) begin
      word_o.valid <= 1'b0;
      data_ready_o <= 1'b0;
    end
  end

  assign stream_o = if_fmt_r[FMT_STREAM_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // general-purpose pins and readback
  assign gp_out_o = gp_out_r[NUM_PINS-1:0];
  assign gp_oe_o  = gp_dir_r[NUM_PINS-1:0];

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd && !pd_r;
      rdata_o  <= 8'h00;
      if (req_i.rd && !pd_r) begin
        unique case (req_i.addr)
          REG_PWR_CLK:   rdata_o <= pwr_clk_r;
          REG_CONV_MODE: rdata_o <= conv_mode_r;
          REG_IF_FMT:    rdata_o <= if_fmt_r;
          REG_FILTER:    rdata_o <= filter_r;
          REG_TARGET:    rdata_o <= target_r;
          REG_DUTY:      rdata_o <= duty_r;
          REG_GP_DIR:    rdata_o <= gp_dir_r;
          REG_GP_OUT:    rdata_o <= gp_out_r;
          REG_GP_IN:     rdata_o <= 8'(gp_s2_r);
          REG_STATUS:    rdata_o <= {4'h0, busy_flag_r, seq_r == S_CONV, clk_src_o};
          default:       rdata_o <= 8'h00;
        endcase
      end
    end
  end

endmodule : power_clock_mode_control

//--- testbench/pcmc_chk.sv
// concurrent checks on the ports of the power and clock mode control block
module pcmc_chk
  import pwr_clk_pkg::*;
#(
  parameter int NUM_PINS = 4
) (
  // clock, reset, straps and serial select pin
  input wire logic                   core_clk_i,
  input wire logic                   reset_i,
  input wire logic                   clock_sel_i,
  input wire logic                   serial_mode_i,
  input wire logic                   cs_n_i,
  // register port, engine and outputs
  input wire pwr_clk_pkg::reg_req_t  req_i,
  input wire logic                   rvalid_o,
  input wire logic                   mod_clk_en_o,
  input wire logic                   conv_run_o,
  input wire logic                   analog_on_o,
  input wire logic                   digital_on_o,
  input wire logic [1:0]             clk_src_o,
  input wire logic                   word_taken_i,
  input wire pwr_clk_pkg::conv_res_t result_i,
  input wire pwr_clk_pkg::out_word_t word_o,
  input wire logic                   stream_o,
  input wire logic [NUM_PINS-1:0]    gp_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic wr_ok;
  // writes only count while the digital side is alive
  assign wr_ok = req_i.wr && digital_on_o;
  ////////////////////////////////////////////////////////////////
  a_div_gap: assert property (mod_clk_en_o |=> !mod_clk_en_o)
    else $error("modulator enable high two cycles running");
  a_cmos_src: assert property (!clock_sel_i |-> clk_src_o == CS_CMOS)
    else $error("strap low without cmos source");
  a_xtal_src: assert property (clock_sel_i && clk_src_o != CS_LVDS |-> clk_src_o == CS_CRYSTAL)
    else $error("strap high without crystal source");
  a_lvds_src: assert property (clk_src_o == CS_LVDS |-> clock_sel_i && serial_mode_i)
    else $error("differential source without strap or serial mode");
  a_pd_entry: assert property (wr_ok && req_i.addr == REG_PWR_CLK && req_i.wdata[2:0] == 3'h4
    |=> !digital_on_o)
    else $error("power-down write did not stop digital side");
  a_pd_quiet: assert property (!digital_on_o |-> !analog_on_o && !conv_run_o && !mod_clk_en_o)
    else $error("block active in power-down");
  a_pd_stay: assert property ((!digital_on_o && cs_n_i) [*6] |=> !digital_on_o)
    else $error("woke without a wake frame");
  a_rd_answer: assert property (req_i.rd && digital_on_o |=> rvalid_o)
    else $error("read not answered");
  a_rd_cause: assert property (rvalid_o |-> $past(req_i.rd) && $past(digital_on_o))
    else $error("read answer without accepted read");
  a_stby_keep: assert property (wr_ok && req_i.addr == REG_PWR_CLK && req_i.wdata[2:0] == 3'h3
    |=> !analog_on_o && digital_on_o)
    else $error("standby state wrong");
  a_word_clr: assert property (word_taken_i && !result_i.valid |=> !word_o.valid)
    else $error("taken word still valid");
  a_stream_bit: assert property (wr_ok && req_i.addr == REG_IF_FMT
    |=> stream_o == |($past(req_i.wdata) & 8'h08))
    else $error("stream output does not follow format");
  a_gp_dir: assert property (wr_ok && req_i.addr == REG_GP_DIR
    |=> gp_oe_o == NUM_PINS'($past(req_i.wdata)))
    else $error("pin drive enables do not follow direction");
endmodule : pcmc_chk

bind power_clock_mode_control pcmc_chk #(.NUM_PINS(NUM_PINS)) chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .clock_sel_i(clock_sel_i),
  .serial_mode_i(serial_mode_i), .cs_n_i(cs_n_i), .req_i(req_i), .rvalid_o(rvalid_o),
  .mod_clk_en_o(mod_clk_en_o), .conv_run_o(conv_run_o), .analog_on_o(analog_on_o),
  .digital_on_o(digital_on_o), .clk_src_o(clk_src_o), .word_taken_i(word_taken_i),
  .result_i(result_i), .word_o(word_o), .stream_o(stream_o), .gp_oe_o(gp_oe_o)
);

//--- testbench/host_model.sv
// host side model that clocks wake frames onto the serial pins
module host_model (
  // clock
  input  wire logic core_clk_i,
  // serial control pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import pwr_clk_pkg::*;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b1;
  end
  // bad adds a stray one mid-frame; sclk stands low between frames
  task wake(input logic bad);
    for (int j = 0; j < WAKE_LEN; j++) begin
      @(negedge core_clk_i);
      cs_n_o <= 1'b0;
      sdi_o  <= (j == 0) || (bad && j == 9);
      repeat (2) @(negedge core_clk_i);
      sclk_o <= 1'b1;
      repeat (2) @(negedge core_clk_i);
      sclk_o <= 1'b0;
    end
    @(negedge core_clk_i);
    cs_n_o <= 1'b1;
    sdi_o  <= ~sdi_o; // released line must not hold its last level
  endtask : wake
endmodule : host_model

//--- testbench/testbench.sv
// self-checking bench for the power and clock mode control block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pwr_clk_pkg::*;
  typedef struct packed {logic [6:0] a; logic [7:0] r, w, v;} row_t;
  logic       core_clk_i = 0, reset_i = 1, clock_sel_i = 0, serial_mode_i = 1;
  logic       start_i = 0, word_taken_i = 0;
  reg_req_t   req_i = '0;
  conv_res_t  result_i = '0;
  logic [3:0] gp_in_i = 4'ha, gp_out_o, gp_oe_o;
  logic [7:0] rdata_o;
  logic       rvalid_o, sclk_i, cs_n_i, sdi_i, mod_clk_en_o, conv_run_o;
  logic       analog_on_o, digital_on_o, data_ready_o, stream_o;
  logic [1:0] clk_src_o, filter_o;
  logic [2:0] target_o;
  out_word_t  word_o;
  logic [39:0] w;
  int         error_cnt = 0, num_checks = 0, i, k, n;
  row_t rows [9] = '{'{REG_PWR_CLK, RST_PWR_CLK, 8'h0a, 8'h0a},
    '{REG_CONV_MODE, RST_CONV_MODE, 8'h00, 8'h00}, '{REG_IF_FMT, RST_IF_FMT, 8'h01, 8'h01},
    '{REG_FILTER, RST_FILTER, 8'h02, 8'h02}, '{REG_TARGET, RST_TARGET, 8'h05, 8'h05},
    '{REG_DUTY, RST_DUTY, 8'h20, 8'h20}, '{REG_GP_DIR, RST_ZERO, 8'h0f, 8'h0f},
    '{REG_GP_OUT, RST_ZERO, 8'h05, 8'h05}, '{REG_GP_IN, 8'h0a, 8'h55, 8'h0a}};
  always #12.5 core_clk_i = ~core_clk_i;
  power_clock_mode_control uut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .clock_sel_i(clock_sel_i), .serial_mode_i(serial_mode_i), .req_i(req_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .sdi_i(sdi_i),
    .start_i(start_i), .result_i(result_i), .mod_clk_en_o(mod_clk_en_o),
    .conv_run_o(conv_run_o), .analog_on_o(analog_on_o), .digital_on_o(digital_on_o),
    .clk_src_o(clk_src_o), .filter_o(filter_o), .target_o(target_o),
    .data_ready_o(data_ready_o), .word_taken_i(word_taken_i), .word_o(word_o),
    .stream_o(stream_o), .gp_in_i(gp_in_i), .gp_out_o(gp_out_o), .gp_oe_o(gp_oe_o));
  host_model host (.core_clk_i(core_clk_i), .sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i));
  ////////////////////////////////////////////////////////////////
  task results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    req_i <= '{1'b1, 1'b0, a, d};
    @(negedge core_clk_i);
    req_i <= '0;
  endtask : wr
  task rd(input logic [6:0] a, input logic [7:0] e, input logic v);
    @(negedge core_clk_i);
    req_i <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk_i);
    req_i <= '0;
    chk("rvalid", v, rvalid_o);
    if (v) chk("rdata", e, rdata_o);
  endtask : rd
  task res();
    @(negedge core_clk_i);
    result_i <= '{1'b1, 24'hc3a55a, 8'h96};
    @(negedge core_clk_i);
    result_i <= '0;
  endtask : res
  function automatic logic [7:0] crc8(input logic [39:0] v, input int len);
    logic [7:0] c;
    c = CRC_SEED;
    for (int j = 0; j < len; j++) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[39-j]) ? CRC_POLY : 8'h00);
    return c;
  endfunction : crc8
  ////////////////////////////////////////////////////////////////
  initial begin
    #1500000;
    error_cnt++;
    $display("BAD watchdog expected done seen hang");
    results();
  end
  initial begin
    repeat (10) @(negedge core_clk_i);
    reset_i = 0;
    foreach (rows[j]) begin
      rd(rows[j].a, rows[j].r, 1'b1);
      wr(rows[j].a, rows[j].w);
      rd(rows[j].a, rows[j].v, 1'b1);
    end
    wr(7'h7f, 8'hff);
    rd(REG_GP_OUT, 8'h05, 1'b1);
    chk("target", 3'h5, target_o);
    chk("gp out", 4'h5, gp_out_o);
    chk("gp oe", 4'hf, gp_oe_o);
    $display("registers done");
    for (k = 0; k < 8; k++) begin
      wr(REG_PWR_CLK, 8'(k << 3));
      repeat (2) begin
        n = 0;
        do begin @(negedge core_clk_i); n++; end while (mod_clk_en_o !== 1'b1 && n < 40);
      end
      chk("div gap", 2 * k + 2, n);
    end
    $display("division done");
    chk("cmos", CS_CMOS, clk_src_o);
    clock_sel_i = 1;
    #1 chk("crystal", CS_CRYSTAL, clk_src_o);
    wr(REG_PWR_CLK, 8'hc0);
    chk("lvds", CS_LVDS, clk_src_o);
    serial_mode_i = 0;
    #1 chk("lvds pin mode", CS_CRYSTAL, clk_src_o);
    serial_mode_i = 1;
    clock_sel_i = 0;
    #1 chk("lvds strap low", CS_CMOS, clk_src_o);
    for (k = 0; k < 3; k++) begin
      wr(REG_PWR_CLK, 8'(k));
      wr(REG_FILTER, 8'(k));
      rd(REG_PWR_CLK, 8'(k), 1'b1);
      chk("analog on", 1'b1, analog_on_o);
      chk("filter", k, filter_o);
    end
    $display("modes done");
    wr(REG_PWR_CLK, 8'h04);
    chk("pd digital", 1'b0, digital_on_o);
    wr(REG_GP_OUT, 8'h0f);
    rd(REG_GP_OUT, 8'h00, 1'b0);
    repeat (8) @(negedge core_clk_i);
    host.wake(1'b1);
    repeat (8) @(negedge core_clk_i);
    chk("bad wake", 1'b0, digital_on_o);
    host.wake(1'b0);
    for (i = 0; i < 20 && digital_on_o !== 1'b1; i++) @(negedge core_clk_i);
    chk("woken", 1'b1, digital_on_o);
    rd(REG_DUTY, RST_DUTY, 1'b1);
    rd(REG_GP_DIR, RST_ZERO, 1'b1);
    $display("power-down done");
    wr(REG_GP_DIR, 8'h0c);
    wr(REG_PWR_CLK, 8'h03);
    chk("stby analog", 1'b0, analog_on_o);
    chk("stby digital", 1'b1, digital_on_o);
    rd(REG_GP_DIR, 8'h0c, 1'b1);
    wr(REG_PWR_CLK, 8'h00);
    wr(REG_CONV_MODE, 8'h01);
    res();
    for (i = 0; i < 20 && analog_on_o !== 1'b0; i++) @(negedge core_clk_i);
    chk("single stby", 1'b0, analog_on_o);
    rd(REG_STATUS, 8'h08, 1'b1);
    wr(REG_CONV_MODE, 8'h00);
    res();
    repeat (3) @(negedge core_clk_i);
    chk("cont run", 1'b1, conv_run_o);
    wr(REG_CONV_MODE, 8'h02);
    repeat (4) @(negedge core_clk_i);
    chk("oneshot idle", 1'b0, conv_run_o);
    start_i = 1;
    for (i = 0; i < 20 && conv_run_o !== 1'b1; i++) @(negedge core_clk_i);
    chk("oneshot run", 1'b1, conv_run_o);
    start_i = 0;
    wr(REG_DUTY, 8'h10);
    wr(REG_CONV_MODE, 8'h03);
    res();
    for (i = 0; i < 20 && analog_on_o !== 1'b0; i++) @(negedge core_clk_i);
    chk("duty rest", 1'b0, analog_on_o);
    for (i = 0; i < 60 && analog_on_o !== 1'b1; i++) @(negedge core_clk_i);
    chk("duty wake", 1'b1, analog_on_o);
    wr(REG_CONV_MODE, 8'h00);
    $display("conversion done");
    for (k = 0; k < 8; k++) begin
      wr(REG_IF_FMT, 8'(k));
      res();
      for (i = 0; i < 20 && word_o.valid !== 1'b1; i++) @(negedge core_clk_i);
      n = k[0] ? 16 : 24;
      w = {24'hc3a55a, 16'h0000};
      if (k[0]) w[23:16] = 8'h00;
      if (k[1]) begin w[39-n -: 8] = 8'h96; n += 8; end
      if (k[2]) begin w[39-n -: 8] = crc8(w, n); n += 8; end
      chk("word bits", n - 1, word_o.nbits);
      chk("word", w, word_o.word);
      chk("ready", 1'b1, data_ready_o);
      @(negedge core_clk_i);
      word_taken_i = 1;
      @(negedge core_clk_i);
      word_taken_i = 0;
      chk("word taken", 1'b0, word_o.valid);
      chk("ready clear", 1'b0, data_ready_o);
    end
    wr(REG_IF_FMT, 8'h08);
    chk("stream", 1'b1, stream_o);
    $display("format done");
    wr(REG_GP_OUT, 8'h09);
    reset_i = 1;
    repeat (2) @(negedge core_clk_i);
    reset_i = 0;
    rd(REG_GP_OUT, RST_ZERO, 1'b1);
    chk("stream reset", 1'b0, stream_o);
    $display("reset done");
    results();
  end
endmodule : testbench
